/* File: verilog/sync_sram_pkg.sv */
// constants and types for the synchronous flow-through sram port control
// Operation
// R1: third chip select active low, sampled
// R2: output enable low drives data pins
// R3: output enable high tri-states data pins
// R4: writes, emerging, deselect mask output enable
// R5: act only when clock qualify sampled low
// R6: clock qualify high holds all state
// R7: sleep request enters sleep, keeps memory
// R8: controller holds sleep low normally
// R9: input data captured on rising edge
// R10: read drives data of previous address
// R11: parity follows data, written per byte
// R12: strap low linear, high interleaved
// R13: all three chip selects select device
// R14: read starts, address latched on load
// R15: write data latched edge after address
// R16: burst counter wraps on two bits
// R17: burst strap sampled continuously, static
`default_nettype none
package sync_sram_pkg;
    // data lane shape
    localparam int BYTE_W = 8;
    localparam int BYTES_DEF = 4;
    localparam int ADDR_W_DEF = 6;
    // burst counter width, fed by the two lowest address bits
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    // reset values of the synchronisers
    localparam logic SLEEP_RST = 1'h0;
    localparam logic MODE_RST = 1'h1;

    // access in progress, one-hot
    typedef enum logic [2:0] {
        OP_IDLE = 3'h1,
        OP_READ = 3'h2,
        OP_WRITE = 3'h4
    } op_t;

    // access state carried between edges
    typedef struct packed {
        op_t op;
        logic [BURST_W-1:0] base;
        logic [BURST_W-1:0] count;
    } burst_t;

    localparam burst_t BURST_RST = '{op: OP_IDLE, base: 2'h0, count: 2'h0};
endpackage
`default_nettype wire

/* File: verilog/sync_sram_port_control.sv */
// port control and array of a synchronous flow-through burst sram
`default_nettype none
module sync_sram_port_control #(
    parameter int ADDR_W = sync_sram_pkg::ADDR_W_DEF,
    parameter int BYTES = sync_sram_pkg::BYTES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronous controls
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic clock_qualify_n,
    input wire logic write_enable_n,
    input wire logic advance_load_n,
    input wire logic [BYTES-1:0] byte_write_sel_n,
    input wire logic [ADDR_W-1:0] address,
    // asynchronous controls and strap
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_mode,
    // data pins
    input wire logic [BYTES*sync_sram_pkg::BYTE_W-1:0] data_in,
    output logic [BYTES*sync_sram_pkg::BYTE_W-1:0] data_out,
    output logic data_oe,
    // parity pins
    input wire logic [BYTES-1:0] parity_in,
    output logic [BYTES-1:0] parity_out,
    output logic parity_oe,
    // status
    output logic asleep
);
    localparam int DW = BYTES * sync_sram_pkg::BYTE_W;
    localparam int UP_W = ADDR_W - sync_sram_pkg::BURST_W;

    ////////////////////////////////////////////////////////////////////////////
    // storage and state

    logic [DW-1:0] mem_data [2**ADDR_W]; // data array, never reset
    logic [BYTES-1:0] mem_par [2**ADDR_W]; // parity array, one bit per byte
    sync_sram_pkg::burst_t acc_ff; // current access
    sync_sram_pkg::burst_t nxt_acc; // access after this edge
    logic [UP_W-1:0] upper_ff; // latched upper address
    logic [UP_W-1:0] nxt_upper;
    logic [DW-1:0] rd_data_ff; // data shown during a read cycle
    logic [BYTES-1:0] rd_par_ff; // parity shown during a read cycle
    logic sleep_meta_ff; // first synchroniser stage, read only by the second
    logic sleep_sync_ff;
    logic mode_meta_ff;
    logic mode_ff; // burst order strap, high means interleaved
    logic live; // this edge counts
    logic selected; // all chip selects active
    logic [ADDR_W-1:0] cur_addr; // address of the access in progress
    logic [ADDR_W-1:0] nxt_addr;

    // burst address: linear adds the count, interleaved xors it
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [UP_W-1:0] upper,
        input logic [1:0] base,
        input logic [1:0] count,
        input logic interleave
    );
        logic [1:0] low;
        low = interleave ? (base ^ count) : 2'(base + count); // [R12]
        return {upper, low};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers for the asynchronous sleep input and the strap

    // both pass two flops; an open sleep pin is assumed pulled low outside
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_meta_ff <= sync_sram_pkg::SLEEP_RST;
            sleep_sync_ff <= sync_sram_pkg::SLEEP_RST;
        end else begin
            sleep_meta_ff <= sleep_request; // [R8]
            sleep_sync_ff <= sleep_meta_ff; // [R7]
        end
    end

    // the strap is followed every cycle; changing it mid-burst is not supported
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_meta_ff <= sync_sram_pkg::MODE_RST;
            mode_ff <= sync_sram_pkg::MODE_RST;
        end else begin
            mode_meta_ff <= burst_mode; // [R17]
            mode_ff <= mode_meta_ff; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge qualification and access sequencing

    // sleep also masks edges, so nothing moves while the array idles
    assign live = !clock_qualify_n && !sleep_sync_ff; // [R5] [R7]
    assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n; // [R1] [R13]
    assign asleep = sleep_sync_ff;
    assign cur_addr = burst_addr(upper_ff, acc_ff.base, acc_ff.count, mode_ff);
    assign nxt_addr = burst_addr(nxt_upper, nxt_acc.base, nxt_acc.count, mode_ff);

    // next access: load on advance_load low, otherwise step the burst
    always_comb begin
        nxt_acc = acc_ff;
        nxt_upper = upper_ff;
        if (live) begin
            if (!advance_load_n) begin
                if (selected) begin
                    // write enable decides the kind for the whole burst
                    nxt_acc.op = write_enable_n ? sync_sram_pkg::OP_READ
                                                : sync_sram_pkg::OP_WRITE; // [R14]
                    nxt_acc.base = address[1:0]; // [R16]
                    nxt_acc.count = sync_sram_pkg::BURST_ZERO;
                    nxt_upper = address[ADDR_W-1:2]; // [R14]
                end else begin
                    nxt_acc.op = sync_sram_pkg::OP_IDLE; // [R1]
                end
            end else begin
                // two-bit counter wraps after four accesses
                nxt_acc.count = acc_ff.count + sync_sram_pkg::BURST_STEP; // [R16]
            end
        end
    end

    // state register; a masked edge leaves it untouched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_ff <= sync_sram_pkg::BURST_RST;
            upper_ff <= '0;
        end else begin
            acc_ff <= nxt_acc; // [R6]
            upper_ff <= nxt_upper; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data phase: data and byte selects of the edge after the address

    always_ff @(posedge clk) begin
        if (live && acc_ff.op == sync_sram_pkg::OP_WRITE) begin
            for (int b = 0; b < BYTES; b++) begin
                if (!byte_write_sel_n[b]) begin
                    mem_data[cur_addr][b*sync_sram_pkg::BYTE_W +: sync_sram_pkg::BYTE_W] <=
                        data_in[b*sync_sram_pkg::BYTE_W +: sync_sram_pkg::BYTE_W]; // [R9] [R15]
                    mem_par[cur_addr][b] <= parity_in[b]; // [R11]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data: fetched at the address edge, shown the following cycle

    // a write landing on the same word at this edge is forwarded byte by byte,
    // otherwise a write-then-read would return stale bytes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
            rd_par_ff <= '0;
        end else if (live) begin
            rd_data_ff <= mem_data[nxt_addr]; // [R10]
            rd_par_ff <= mem_par[nxt_addr];
            if (acc_ff.op == sync_sram_pkg::OP_WRITE && cur_addr == nxt_addr) begin
                for (int b = 0; b < BYTES; b++) begin
                    if (!byte_write_sel_n[b]) begin
                        rd_data_ff[b*sync_sram_pkg::BYTE_W +: sync_sram_pkg::BYTE_W] <=
                            data_in[b*sync_sram_pkg::BYTE_W +: sync_sram_pkg::BYTE_W];
                        rd_par_ff[b] <= parity_in[b];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin direction

    // output enable acts without the clock; write and deselect cycles mask it
    assign data_oe = !output_enable_n && !sleep_sync_ff
                     && acc_ff.op == sync_sram_pkg::OP_READ; // [R2] [R3] [R4]
    assign parity_oe = data_oe; // [R11]
    assign data_out = rd_data_ff; // [R10]
    assign parity_out = rd_par_ff; // [R11]

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_oe_write_mask: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        acc_ff.op == sync_sram_pkg::OP_WRITE |-> !data_oe && !parity_oe)
        else $error("data pins driven during write data cycle");

    a_oe_desel_mask: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (live && !advance_load_n && !selected) |=> !data_oe)
        else $error("data pins driven while deselected");

    a_oe_drives_read: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        (acc_ff.op == sync_sram_pkg::OP_READ && !output_enable_n && !sleep_sync_ff)
        |-> data_oe && data_out == rd_data_ff)
        else $error("read with output enable low not driven");

    a_oe_high_off: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        output_enable_n |-> !data_oe)
        else $error("data pins driven with output enable high");

    a_qualify_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        clock_qualify_n |=> $stable(acc_ff) && $stable(upper_ff) && $stable(rd_data_ff))
        else $error("state moved on a masked edge");

    a_read_load: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        (live && selected && write_enable_n && !advance_load_n)
        |=> acc_ff.op == sync_sram_pkg::OP_READ && acc_ff.count == 2'h0
            && {upper_ff, acc_ff.base} == $past(address))
        else $error("read not started on load edge");

    a_write_load: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        (live && selected && !write_enable_n && !advance_load_n)
        |=> acc_ff.op == sync_sram_pkg::OP_WRITE)
        else $error("write not started on load edge");

    a_burst_wrap: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        (live && advance_load_n) |=> acc_ff.count == 2'($past(acc_ff.count) + 2'h1)
            && acc_ff.op == $past(acc_ff.op))
        else $error("burst counter did not step");

    a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        sleep_sync_ff |-> !data_oe ##1 $stable(acc_ff))
        else $error("state moved or pins driven while asleep");

    c_read_burst: cover property (@(posedge clk) disable iff (!rst_n)
        (acc_ff.op == sync_sram_pkg::OP_READ && live && advance_load_n) [*3]);
    c_write_read: cover property (@(posedge clk) disable iff (!rst_n)
        acc_ff.op == sync_sram_pkg::OP_WRITE ##1 acc_ff.op == sync_sram_pkg::OP_READ);
    c_stall_read: cover property (@(posedge clk) disable iff (!rst_n)
        (acc_ff.op == sync_sram_pkg::OP_READ && clock_qualify_n) [*2]);
    c_sleep: cover property (@(posedge clk) disable iff (!rst_n) $rose(sleep_sync_ff));
endmodule
`default_nettype wire

/* File: test/sram_host_model.sv */
// memory controller model: drives write data and the sleep request
`default_nettype none
module sram_host_model (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic drive_en,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wpar,
    input wire logic sleep_cmd,
    // pins towards the sram
    output logic [31:0] data_in,
    output logic [3:0] parity_in,
    output logic sleep_request
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] idle_d_ff = 32'h0; // released data pattern
    logic [3:0] idle_p_ff = 4'h0; // released parity pattern
    // released lines change every cycle so stale data never looks valid
    always_ff @(posedge clk) begin
        idle_d_ff <= ~data_in;
        idle_p_ff <= ~parity_in;
    end
    assign data_in = drive_en ? wdata : idle_d_ff;
    assign parity_in = drive_en ? wpar : idle_p_ff;
    // sleep held low in normal operation, raised only on command
    assign sleep_request = sleep_cmd;
endmodule
`default_nettype wire

/* File: test/tb_sync_sram_port_control.sv */
// self-checking bench for the sram port control
`default_nettype none
module tb_sync_sram_port_control;
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////
    logic clk, rst_n, chip_select_a_n, chip_select_b, chip_select_c_n, clock_qualify_n;
    logic write_enable_n, advance_load_n, output_enable_n, burst_mode, drive_en, sleep_cmd;
    logic sleep_request, data_oe, parity_oe, asleep;
    logic [3:0] byte_write_sel_n, parity_in, parity_out, wpar;
    logic [5:0] address;
    logic [31:0] data_in, data_out, wdata;
    logic [31:0] exp_w [4]; // expected words, index = low address bits minus one
    logic [3:0] exp_p [4];
    int mismatches = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////
    sync_sram_port_control sync_sram_port_control_inst (.clk(clk), .rst_n(rst_n),
        .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
        .chip_select_c_n(chip_select_c_n), .clock_qualify_n(clock_qualify_n),
        .write_enable_n(write_enable_n), .advance_load_n(advance_load_n),
        .byte_write_sel_n(byte_write_sel_n), .address(address),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .burst_mode(burst_mode), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .parity_in(parity_in), .parity_out(parity_out), .parity_oe(parity_oe),
        .asleep(asleep));
    sram_host_model sram_host_model_inst (.clk(clk), .drive_en(drive_en), .wdata(wdata),
        .wpar(wpar), .sleep_cmd(sleep_cmd), .data_in(data_in), .parity_in(parity_in),
        .sleep_request(sleep_request));
    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // load edge; sel=0 drops one select to deselect
    task automatic load(input logic sel, input logic we_n);
        chip_select_a_n = 1'h0;
        chip_select_b = sel;
        chip_select_c_n = 1'h0;
        write_enable_n = we_n;
        advance_load_n = 1'h0;
        address = 6'h05;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_asleep(input logic v);
        for (int i = 0; i < 8 && asleep !== v; i++) tick();
        if (asleep !== v) begin
            mismatches++;
            $display("[ERR] asleep expected %0d seen %0d", v, asleep);
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_burst_write();
        load(1'h1, 1'h0);
        tick();
        for (int k = 0; k < 4; k++) begin
            drive_en = 1'h1;
            wdata = 32'h5A000000 + 32'(k) * 32'h01010101;
            wpar = 4'(k * 5 + 2);
            exp_w[k] = wdata;
            exp_p[k] = wpar;
            chk("oe in write data cycle", 32'h0, {31'h0, data_oe | parity_oe});
            if (k < 3) advance_load_n = 1'h1;
            else load(1'h0, 1'h1);
            tick();
        end
        drive_en = 1'h0;
        $display("burst write done");
    endtask
    task automatic t_byte_write();
        load(1'h1, 1'h0);
        tick();
        drive_en = 1'h1;
        wdata = 32'hFFFFFFFF;
        wpar = 4'hF;
        byte_write_sel_n = 4'hA;
        exp_w[0] = (exp_w[0] & 32'hFF00FF00) | 32'h00FF00FF;
        exp_p[0] = (exp_p[0] & 4'hA) | 4'h5;
        // read of the same word on the write data edge must see the new bytes
        load(1'h1, 1'h1);
        tick();
        chk("forwarded word", exp_w[0], data_out);
        chk("forwarded parity", {28'h0, exp_p[0]}, {28'h0, parity_out});
        drive_en = 1'h0;
        byte_write_sel_n = 4'h0;
        $display("byte write done");
    endtask
    // reads a four-beat burst from the same base, with a stalled beat
    task automatic t_read_burst(input logic mode);
        logic [1:0] low;
        burst_mode = mode;
        output_enable_n = 1'h0;
        repeat (3) tick();
        load(1'h1, 1'h1);
        tick();
        for (int k = 0; k < 4; k++) begin
            low = mode ? (2'h1 ^ 2'(k)) : 2'(k + 1);
            chk("read word", exp_w[low - 2'h1], data_out);
            chk("read parity", {28'h0, exp_p[low - 2'h1]}, {28'h0, parity_out});
            chk("read oe", 32'h1, {31'h0, data_oe & parity_oe});
            if (k == 1) begin
                clock_qualify_n = 1'h1;
                repeat (2) tick();
                chk("stalled word", exp_w[low - 2'h1], data_out);
                clock_qualify_n = 1'h0;
            end
            if (k < 3) advance_load_n = 1'h1;
            else load(1'h0, 1'h1);
            tick();
        end
        $display("read burst done, mode %0d", mode);
    endtask
    task automatic t_oe_select();
        for (int i = 0; i < 4; i++) begin
            load(1'h1, 1'h1);
            chip_select_a_n = (i == 0);
            chip_select_b = (i != 1);
            chip_select_c_n = (i == 2);
            tick();
            chk("oe after select", {31'h0, i == 3}, {31'h0, data_oe});
        end
        output_enable_n = 1'h1;
        #1;
        chk("oe released", 32'h0, {31'h0, data_oe | parity_oe});
        output_enable_n = 1'h0;
        #1;
        chk("oe driven", 32'h1, {31'h0, data_oe});
        $display("output enable test done");
    endtask
    task automatic t_sleep();
        sleep_cmd = 1'h1;
        wait_asleep(1'h1);
        chk("oe asleep", 32'h0, {31'h0, data_oe});
        sleep_cmd = 1'h0;
        wait_asleep(1'h0);
        load(1'h1, 1'h1);
        tick();
        chk("word kept", exp_w[0], data_out);
        $display("sleep test done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
        {clock_qualify_n, write_enable_n, advance_load_n, output_enable_n} = 4'h3;
        {burst_mode, drive_en, sleep_cmd} = 3'h0;
        byte_write_sel_n = 4'h0;
        address = 6'h00;
        wdata = 32'h0;
        wpar = 4'h0;
        repeat (10) tick();
        chk("reset oe", 32'h0, {31'h0, data_oe | asleep});
        rst_n = 1'h1;
        repeat (3) tick();
        t_burst_write();
        t_read_burst(1'h0);
        t_byte_write();
        t_read_burst(1'h1);
        t_oe_select();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
